/* logic/tblwr_pkg.sv */
package tblwr_pkg;
  localparam int PTR_W       = 21;
  localparam int DATA_W      = 8;
  localparam int HOLD_N      = 8;
  localparam int SEL_W       = 3;
  localparam int MODE_W      = 2;
  localparam int QCNT_W      = 2;
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [1:0] MODE_POSTDEC = 2'h2;
  localparam logic [1:0] MODE_PREINC = 2'h3;
  localparam logic [20:0] PTR_RESET = 21'h000000;
  localparam logic [20:0] PTR_ONE = 21'h000001;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [1:0] Q_LAST = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_DECODE = 3'b010,
    ST_WRITE  = 3'b100
  } state_t;
endpackage

/* logic/hold_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface hold_if;
  logic       we;
  logic [2:0] waddr;
  logic [7:0] wdata;
  logic [2:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* logic/hold_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module hold_mem (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Port
  hold_if.mem       hp
);
  logic [tblwr_pkg::DATA_W-1:0] mem_reg [tblwr_pkg::HOLD_N];
  logic [tblwr_pkg::DATA_W-1:0] rdata_reg;

  genvar gi;
  generate
    for (gi = 0; gi < tblwr_pkg::HOLD_N; gi++) begin : g_ent
      // Each entry only stages a byte; nothing here reaches program memory.
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          mem_reg[gi] <= tblwr_pkg::HOLD_RESET;
        end else if (hp.we && hp.waddr == 3'(gi)) begin
          mem_reg[gi] <= hp.wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= tblwr_pkg::HOLD_RESET;
    end else begin
      rdata_reg <= mem_reg[hp.raddr];
    end
  end
  assign hp.rdata = rdata_reg;
endmodule // hold_mem
`default_nettype wire

/* logic/table_write_holding_path.sv */
`timescale 1ns/1ps
`default_nettype none
module table_write_holding_path (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Instruction issue from the core
  input  wire logic        table_write_instruction,
  input  wire logic [1:0]  write_mode,
  input  wire logic [7:0]  table_latch,
  // Pointer load from the core
  input  wire logic        ptr_load,
  input  wire logic [20:0] ptr_load_value,
  // Status
  output logic             busy,
  output logic             done,
  output logic [20:0]      table_pointer,
  output logic [3:0]       q_phase,
  // Holding register readout for the programming sequencer
  input  wire logic [2:0]  hold_raddr,
  output logic [7:0]       hold_rdata,
  output logic             hold_we,
  output logic             byte_is_high
);
  // ----------------------------------------------------------------
  // State and quarter counter
  // ----------------------------------------------------------------
  tblwr_pkg::state_t state_reg, state_next;
  logic [1:0]  q_reg;
  logic [1:0]  mode_reg;
  logic [20:0] ptr_reg, ptr_next;
  logic        done_reg;
  logic        q_end;
  logic        start;
  logic        write_now;
  logic [20:0] ptr_inc;
  logic [20:0] ptr_dec;
  logic [20:0] addr_used;

  assign q_end     = (q_reg == tblwr_pkg::Q_LAST);
  assign start     = (state_reg == tblwr_pkg::ST_IDLE) && table_write_instruction;
  assign ptr_inc   = ptr_reg + tblwr_pkg::PTR_ONE;
  assign ptr_dec   = ptr_reg - tblwr_pkg::PTR_ONE;
  // Pre-increment uses the advanced address for the write itself.
  assign addr_used = (mode_reg == tblwr_pkg::MODE_PREINC) ? ptr_inc : ptr_reg;
  // Write happens in the second cycle, last quarter.
  assign write_now = (state_reg == tblwr_pkg::ST_WRITE) && q_end;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tblwr_pkg::ST_IDLE:   if (start) state_next = tblwr_pkg::ST_DECODE;
      tblwr_pkg::ST_DECODE: if (q_end) state_next = tblwr_pkg::ST_WRITE;
      tblwr_pkg::ST_WRITE:  if (q_end) state_next = tblwr_pkg::ST_IDLE;
      default:              state_next = tblwr_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    ptr_next = ptr_reg;
    if (write_now) begin
      case (mode_reg)
        tblwr_pkg::MODE_NONE:    ptr_next = ptr_reg;
        tblwr_pkg::MODE_POSTINC: ptr_next = ptr_inc;
        tblwr_pkg::MODE_POSTDEC: ptr_next = ptr_dec;
        tblwr_pkg::MODE_PREINC:  ptr_next = ptr_inc;
        default:                 ptr_next = ptr_reg;
      endcase
    end else if (ptr_load && state_reg == tblwr_pkg::ST_IDLE) begin
      ptr_next = ptr_load_value;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= tblwr_pkg::ST_IDLE;
      q_reg     <= '0;
      mode_reg  <= tblwr_pkg::MODE_NONE;
      ptr_reg   <= tblwr_pkg::PTR_RESET;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      q_reg     <= (state_reg == tblwr_pkg::ST_IDLE) ? 2'h0 : q_reg + 2'h1;
      if (start) mode_reg <= write_mode;
      ptr_reg   <= ptr_next;
      done_reg  <= write_now;
    end
  end

  // ----------------------------------------------------------------
  // Holding registers
  // ----------------------------------------------------------------
  hold_if hb ();
  assign hb.we    = write_now;
  assign hb.waddr = addr_used[tblwr_pkg::SEL_W-1:0];
  assign hb.wdata = table_latch;
  assign hb.raddr = hold_raddr;

  hold_mem u_hold (
    .clk    (clk),
    .arst_n (arst_n),
    .hp     (hb)
  );

  assign busy          = (state_reg != tblwr_pkg::ST_IDLE);
  assign done          = done_reg;
  assign table_pointer = ptr_reg;
  assign q_phase       = busy ? (4'h1 << q_reg) : 4'h0;
  assign hold_rdata    = hb.rdata;
  assign hold_we       = write_now;
  assign byte_is_high  = addr_used[0];

  // ----------------------------------------------------------------
  // Check helpers
  // ----------------------------------------------------------------
  // The span counter measures one write, so its length is checked
  // without a long repetition inside a property.
  logic [3:0] span_reg;
  logic [2:0] next_low;
  logic       expect_high;
  logic       plain_mode;
  logic [7:0] entry_hit;

  // The expected entry and byte are rebuilt from the visible pointer,
  // not from the address path that the write itself uses.
  assign next_low    = table_pointer[2:0] + 3'h1;
  assign plain_mode  = (mode_reg != tblwr_pkg::MODE_PREINC);
  assign expect_high = plain_mode ? table_pointer[0] : ~table_pointer[0];

  // One flag per entry, so that a write can be seen to pick exactly one.
  genvar ei;
  generate
    for (ei = 0; ei < tblwr_pkg::HOLD_N; ei++) begin : g_hit
      assign entry_hit[ei] = write_now && (hb.waddr == 3'(ei));
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      span_reg <= 4'h0;
    end else begin
      span_reg <= busy ? span_reg + 4'h1 : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_two_cycles: assert property (@(posedge clk) disable iff (!arst_n)
    start |=> busy [*8] ##1 !busy) else $error("write not two cycles");
  chk_write_pos: assert property (@(posedge clk) disable iff (!arst_n)
    start |-> ##8 (hold_we && q_phase == 4'h8) ##1 done) else $error("write at wrong quarter");
  chk_post_inc: assert property (@(posedge clk) disable iff (!arst_n)
    write_now && mode_reg == tblwr_pkg::MODE_POSTINC |=>
    table_pointer == $past(table_pointer) + tblwr_pkg::PTR_ONE) else $error("post inc bad");
  chk_post_dec: assert property (@(posedge clk) disable iff (!arst_n)
    write_now && mode_reg == tblwr_pkg::MODE_POSTDEC |=>
    table_pointer == $past(table_pointer) - tblwr_pkg::PTR_ONE) else $error("post dec bad");
  chk_no_change: assert property (@(posedge clk) disable iff (!arst_n)
    write_now && mode_reg == tblwr_pkg::MODE_NONE |=> $stable(table_pointer))
    else $error("pointer moved");
  chk_busy_ptr: assert property (@(posedge clk) disable iff (!arst_n)
    busy && !write_now |=> $stable(table_pointer)) else $error("pointer moved while busy");
  chk_byte_sel: assert property (@(posedge clk) disable iff (!arst_n)
    write_now |-> byte_is_high == expect_high) else $error("byte select bad");
  chk_hold_data: assert property (@(posedge clk) disable iff (!arst_n)
    write_now ##1 (hold_raddr == $past(addr_used[2:0])) |=> hold_rdata == $past(table_latch, 2))
    else $error("holding data bad");
  chk_one_write: assert property (@(posedge clk) disable iff (!arst_n)
    hold_we |=> !hold_we [*7]) else $error("extra holding write");

  // Pointer wrap, the idle pointer load and the variant that moves the pointer first.
  chk_pre_inc: assert property (@(posedge clk) disable iff (!arst_n)
    write_now && mode_reg == tblwr_pkg::MODE_PREINC |=>
    table_pointer == $past(table_pointer) + tblwr_pkg::PTR_ONE) else $error("pre inc bad");
  chk_ptr_wrap: assert property (@(posedge clk) disable iff (!arst_n)
    write_now && mode_reg == tblwr_pkg::MODE_POSTINC && (&table_pointer) |=>
    table_pointer == 21'h000000) else $error("pointer did not wrap");
  chk_idle_load: assert property (@(posedge clk) disable iff (!arst_n)
    ptr_load && !busy |=> table_pointer == $past(ptr_load_value))
    else $error("pointer load lost");

  // Which holding entry a write lands in.
  chk_pre_entry: assert property (@(posedge clk) disable iff (!arst_n)
    write_now && !plain_mode |-> hb.waddr == next_low) else $error("pre inc entry bad");
  chk_plain_entry: assert property (@(posedge clk) disable iff (!arst_n)
    write_now && plain_mode |-> hb.waddr == table_pointer[2:0]) else $error("entry bad");
  chk_one_entry: assert property (@(posedge clk) disable iff (!arst_n)
    $onehot0(entry_hit)) else $error("several entries written");
  chk_entry_hit: assert property (@(posedge clk) disable iff (!arst_n)
    hold_we |-> $onehot(entry_hit)) else $error("no entry written");

  // Quarter sequencing inside the two instruction cycles.
  chk_quarter_hot: assert property (@(posedge clk) disable iff (!arst_n)
    busy |-> $onehot(q_phase)) else $error("quarter not one-hot");
  chk_quarter_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !busy |-> q_phase == 4'h0) else $error("quarter while idle");
  chk_quarter_step: assert property (@(posedge clk) disable iff (!arst_n)
    busy && q_phase != 4'h8 |=> q_phase == ($past(q_phase) << 1))
    else $error("quarter skipped");
  chk_start_q1: assert property (@(posedge clk) disable iff (!arst_n)
    start |=> busy && q_phase == 4'h1) else $error("decode not in first quarter");
  chk_state_hot: assert property (@(posedge clk) disable iff (!arst_n)
    $onehot(state_reg)) else $error("state not one-hot");
  chk_mode_kept: assert property (@(posedge clk) disable iff (!arst_n)
    busy |=> $stable(mode_reg)) else $error("variant changed mid write");

  // Length of the two instruction cycles and the end of the write.
  chk_decode_len: assert property (@(posedge clk) disable iff (!arst_n)
    start |=> (state_reg == tblwr_pkg::ST_DECODE) [*4] ##1 (state_reg == tblwr_pkg::ST_WRITE))
    else $error("first cycle length bad");
  chk_write_len: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == tblwr_pkg::ST_DECODE && q_end |=>
    (state_reg == tblwr_pkg::ST_WRITE) [*4] ##1 (state_reg == tblwr_pkg::ST_IDLE))
    else $error("second cycle length bad");
  chk_span_bound: assert property (@(posedge clk) disable iff (!arst_n)
    busy |-> span_reg < 4'h8) else $error("write too long");
  chk_span_write: assert property (@(posedge clk) disable iff (!arst_n)
    hold_we |-> span_reg == 4'h7) else $error("holding write off its quarter");
  chk_done_after: assert property (@(posedge clk) disable iff (!arst_n)
    hold_we |=> done && !busy) else $error("done late");
  chk_done_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    done |=> !done) else $error("done too long");
  chk_idle_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    !busy |-> !hold_we) else $error("holding write while idle");
endmodule // table_write_holding_path
`default_nettype wire

/* tb/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and completion
  input  wire logic  clk,
  input  wire logic  done,
  // Instruction issue
  output logic       instr,
  output logic [1:0] mode,
  output logic [7:0] latch
);
  initial begin
    instr = 1'b0;
    mode  = 2'h0;
    latch = 8'h00;
  end
  // The latch byte moves on once the write is over, so a late sample shows up.
  always @(posedge clk) begin
    if (done) begin
      latch <= ~latch;
    end
  end
  task automatic issue(input logic [1:0] m, input logic [7:0] d);
    @(posedge clk);
    #1;
    instr = 1'b1;
    mode  = m;
    latch = d;
    @(posedge clk);
    #1;
    instr = 1'b0;
    mode  = ~m;
  endtask
endmodule // core_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, arst_n, ptr_load, instr, busy, done, hold_we, byte_is_high;
  logic [20:0] ptr_load_value, table_pointer, exp_ptr;
  logic [2:0]  hold_raddr;
  logic [3:0]  q_phase;
  logic [1:0]  mode;
  logic [7:0]  latch, hold_rdata;
  logic [7:0]  exp_hold [8];
  int          mismatches, num_checks;
  core_model i_core (.clk(clk), .done(done), .instr(instr), .mode(mode), .latch(latch));
  table_write_holding_path i_dut (.clk(clk), .arst_n(arst_n), .table_write_instruction(instr),
    .write_mode(mode), .table_latch(latch), .ptr_load(ptr_load), .ptr_load_value(ptr_load_value),
    .busy(busy), .done(done), .table_pointer(table_pointer), .q_phase(q_phase),
    .hold_raddr(hold_raddr), .hold_rdata(hold_rdata), .hold_we(hold_we),
    .byte_is_high(byte_is_high));
  function automatic logic [20:0] eff(input logic [20:0] p, input logic [1:0] m);
    return (m == tblwr_pkg::MODE_PREINC) ? p + 21'h000001 : p;
  endfunction
  function automatic logic [20:0] nxt(input logic [20:0] p, input logic [1:0] m);
    return (m == tblwr_pkg::MODE_NONE) ? p : (m == tblwr_pkg::MODE_POSTDEC) ? p - 21'h000001
      : p + 21'h000001;
  endfunction
  task automatic cmp_ptr(input string what, input logic [20:0] e, input logic [20:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check_hold;
    for (int i = 0; i < 8; i++) begin
      hold_raddr = 3'(i);
      @(posedge clk);
      #1;
      cmp_byte("holding byte", exp_hold[i], hold_rdata);
      cmp_byte("done pulse", 8'h00, {7'h00, done});
    end
  endtask
  task automatic load_ptr(input logic [20:0] v);
    ptr_load = 1'b1;
    ptr_load_value = v;
    @(posedge clk);
    #1;
    ptr_load = 1'b0;
    exp_ptr = v;
  endtask
  // Loads requested while busy must be ignored.
  task automatic do_write(input logic [1:0] m, input logic [7:0] d);
    logic [20:0] ea;
    int n;
    int we_n;
    ea = eff(exp_ptr, m);
    exp_hold[ea[2:0]] = d;
    exp_ptr = nxt(exp_ptr, m);
    n = 0;
    we_n = 0;
    i_core.issue(m, d);
    while (done !== 1'b1 && n < 20) begin
      cmp_byte("busy", 8'h01, {7'h00, busy});
      cmp_byte("quarter", 8'h01 << (n % 4), {4'h0, q_phase});
      ptr_load = busy & 1'($urandom);
      ptr_load_value = 21'($urandom);
      n++;
      if (hold_we === 1'b1) begin
        we_n++;
        cmp_byte("byte select", {7'h00, ea[0]}, {7'h00, byte_is_high});
      end
      @(posedge clk);
      #1;
    end
    ptr_load = 1'b0;
    cmp_byte("busy cycles", 8'h08, 8'(n));
    cmp_byte("busy end", 8'h00, {7'h00, busy});
    cmp_byte("write strobes", 8'h01, 8'(we_n));
    cmp_ptr("pointer", exp_ptr, table_pointer);
    check_hold();
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end
  initial begin
    arst_n = 1'b0;
    ptr_load = 1'b0;
    ptr_load_value = 21'h000000;
    hold_raddr = 3'h0;
    mismatches = 0;
    num_checks = 0;
    exp_ptr = 21'h000000;
    foreach (exp_hold[i]) exp_hold[i] = 8'h00;
    void'($urandom(32'h32e6));
    repeat (20) @(posedge clk);
    #1;
    arst_n = 1'b1;
    cmp_ptr("reset pointer", 21'h000000, table_pointer);
    check_hold();
    for (int k = 0; k < 40; k++) begin
      if (k % 8 == 0) load_ptr(k == 0 ? 21'h1fffff : 21'($urandom));
      do_write(k < 4 ? 2'(k) : 2'($urandom), 8'($urandom));
    end
    // A reset in the middle of a write abandons it and clears pointer and entries.
    i_core.issue(tblwr_pkg::MODE_POSTINC, 8'($urandom));
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1'b0;
    #1;
    cmp_byte("reset busy", 8'h00, {7'h00, busy});
    cmp_byte("reset quarter", 8'h00, {4'h0, q_phase});
    @(posedge clk);
    #1;
    arst_n = 1'b1;
    exp_ptr = 21'h000000;
    foreach (exp_hold[i]) exp_hold[i] = 8'h00;
    cmp_ptr("reset pointer", 21'h000000, table_pointer);
    check_hold();
    for (int k = 0; k < 4; k++) begin
      do_write(2'(3 - k), 8'($urandom));
    end
    end_sim();
  end
endmodule // tb
`default_nettype wire
